// *** abc_pkg.sv ***
// abc_pkg: shared constants and types for the board control register block
package abc_pkg;

    // ==========================================================
    // clock rate and documented times
    localparam int CLK_MHZ        = 100;        // system clock, 10 ns period
    localparam int T_PCI_LOAD_US  = 3000;       // pci config load, 3 ms max
    localparam int T_ROM_CFG_US   = 300000;     // logic config from rom, 300 ms
    localparam int T_LOGIC_INI_US = 3000;       // logic initialise, 3 ms
    localparam int T_RATE_INI_US  = 250000;     // rate generator init, 250 ms
    localparam int T_LIVE_US      = 400000;     // status settles, 400 ms
    localparam int T_BUFSZ_US     = 500000;     // buffer size valid, 500 ms

    // times convert exactly to whole cycles
    localparam int CYC_PCI_LOAD   = T_PCI_LOAD_US * CLK_MHZ;
    localparam int CYC_ROM_CFG    = T_ROM_CFG_US * CLK_MHZ;
    localparam int CYC_LOGIC_INI  = T_LOGIC_INI_US * CLK_MHZ;
    localparam int CYC_RATE_INI   = T_RATE_INI_US * CLK_MHZ;
    localparam int CYC_LIVE       = T_LIVE_US * CLK_MHZ;
    localparam int CYC_BUFSZ      = T_BUFSZ_US * CLK_MHZ;

    // ==========================================================
    // register map
    localparam int              ADDR_W        = 7;      // 32 longwords
    localparam logic [4:0]      OFS_CTRL_WORD = 5'h00;  // longword index
    localparam int              CTRL_W        = 18;     // implemented bits
    localparam logic [17:0]     CTRL_RST      = 18'h0383C;

    // field encodings
    localparam logic [1:0] CFG_DIFF   = 2'h0;
    localparam logic [1:0] CFG_SINGLE = 2'h1;
    localparam logic [1:0] CFG_ZERO   = 2'h2;
    localparam logic [1:0] CFG_VREF   = 2'h3;
    localparam logic [1:0] SPAN_10V   = 2'h3;

    // interrupt event codes
    localparam logic [2:0] IRQ_EV_INIT     = 3'h0;
    localparam logic [2:0] IRQ_EV_AUTOCAL  = 3'h1;
    localparam logic [2:0] IRQ_EV_READY    = 3'h2;
    localparam logic [2:0] IRQ_EV_THR_RISE = 3'h3;
    localparam logic [2:0] IRQ_EV_THR_FALL = 3'h4;

    // ==========================================================
    // main control word layout, bit 0 at the right
    typedef struct packed {
        logic       clr_on_sync;    // 17
        logic       lockstep_scan;  // 16
        logic       init_b;         // 15
        logic       thr_flag;       // 14
        logic       ready;          // 13
        logic       cal_pass;       // 12
        logic       irq_flag;       // 11
        logic [2:0] irq_event_select; // 10:8
        logic       cal_b;          // 7
        logic       sync_b;         // 6
        logic       master;         // 5
        logic       fmt_ob;         // 4
        logic [1:0] span;           // 3:2
        logic [1:0] input_config_select; // 1:0
    } abc_ctrl_t;

    typedef enum logic [2:0] {
        ST_CFG_PCI,
        ST_CFG_ROM,
        ST_INIT_LOGIC,
        ST_INIT_RATE,
        ST_RUN
    } abc_stage_t;

    // register bus request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic              wr;
        logic              rd;
        logic [31:0]       wdata;
    } abc_req_t;

    // analog side status, same clock
    typedef struct packed {
        logic cal_done;
        logic cal_ok;
        logic buf_above_thr;
    } abc_ana_t;

    // strobes towards the analog side
    typedef struct packed {
        logic sync_pulse;
        logic ext_sync;
        logic buf_clear;
        logic cal_start;
        logic settle_req;
    } abc_strb_t;

endpackage

// *** abc_pin_sync.sv ***
// abc_pin_sync: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none

module abc_pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             clk_sys_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] level_out
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] lvl;
    } abc_sync_t;

    abc_sync_t r_q;
    abc_sync_t r_d;

    // ==========================================================
    // next state: a bit moves only when stages two and three agree
    always_comb
    begin
        r_d    = r_q;
        r_d.s1 = pin_in;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (r_q.s2[i] == r_q.s3[i])
            begin
                r_d.lvl[i] = r_q.s3[i];
            end
        end
    end

    // state registers
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r_q <= {INIT, INIT, INIT, INIT};
        end
        else
        begin
            r_q <= r_d;
        end
    end

    assign level_out = r_q.lvl;

endmodule

`default_nettype wire

// *** abc_board_control_register.sv ***
// abc_board_control_register: main control word and config sequencing
//
// Behaviour
// - reserved bits ignored on write, read zero
// - decode a 32-longword aligned register window
// - control word at offset zero, 32 bits
// - bits 1:0 input config, reset differential
// - bits 3:2 input span, reset ten volts
// - bit 4 offset binary format, reset set
// - bit 5 master role, reset high
// - bit 6 sync pulse in master, self-clears
// - bit 7 starts autocalibration, self-clears
// - bits 10:8 interrupt event select, reset zero
// - bit 11 set on request, host clears
// - bit 12 set at reset/cal start, fail clears
// - bit 13 low while channels settle
// - bit 14 high while buffer above threshold, once the 400 ms mark has passed
// - bit 15 reinitialises board, self-clears
// - bit 16 selects discrete scan acquisition
// - bit 17 turns sync into buffer clear
// - reset 0000383C, later 0000783C after 400 ms
// - buffer size valid about 500 ms after init
// - bus reset starts config, retry during load
// - four ordered configuration stages with durations
// - input config codes diff/single/ground/reference
// - init within 253 ms, raises irq, clears bit
// - ready drops on sync/cal, rise is event
`timescale 1ns/1ns
`default_nettype none

module abc_board_control_register #(
    parameter int CYC_PCI_LOAD_P  = abc_pkg::CYC_PCI_LOAD,
    parameter int CYC_ROM_CFG_P   = abc_pkg::CYC_ROM_CFG,
    parameter int CYC_LOGIC_INI_P = abc_pkg::CYC_LOGIC_INI,
    parameter int CYC_RATE_INI_P  = abc_pkg::CYC_RATE_INI,
    parameter int CYC_LIVE_P      = abc_pkg::CYC_LIVE,
    parameter int CYC_BUFSZ_P     = abc_pkg::CYC_BUFSZ
) (
    input  wire logic              clk_sys_in,
    input  wire logic              reset_n_in,
    input  wire logic              pci_rst_n_in,
    input  wire logic              chan_settled_in,
    input  wire abc_pkg::abc_req_t req_in,
    input  wire abc_pkg::abc_ana_t ana_in,
    output logic [31:0]            rdata_out,
    output logic                   rvalid_out,
    output logic                   retry_out,
    output abc_pkg::abc_ctrl_t     ctrl_out,
    output abc_pkg::abc_strb_t     strb_out,
    output logic                   irq_out,
    output logic                   cfg_busy_out,
    output logic                   rate_init_out,
    output logic                   bufsz_ready_out
);
    import abc_pkg::*;

    typedef struct packed {
        abc_stage_t st;
        logic [31:0] tmr;       // stage countdown
        logic [31:0] age;       // cycles since initialisation began
        logic        live;      // 400 ms mark passed
        logic        bufsz;     // 500 ms mark passed
        abc_ctrl_t   ctrl;
        logic        thr_prev;
        logic [31:0] rdata;
        logic        rvalid;
        abc_strb_t   strb;
        logic        settling;  // request made, settled not yet seen low
    } abc_state_t;

    localparam abc_state_t RST_S = '{st: ST_CFG_PCI,
        tmr: 32'(CYC_PCI_LOAD_P - 1), age: 32'h0, live: 1'b0,
        bufsz: 1'b0, ctrl: abc_ctrl_t'(CTRL_RST), thr_prev: 1'b0,
        rdata: 32'h0, rvalid: 1'b0, strb: '0, settling: 1'b0};

    abc_state_t r_q;
    abc_state_t r_d;
    logic [1:0] pin_lvl;
    logic       pci_rst_n_s;
    logic       settled_s;
    logic       hit_ctrl;
    logic       wr_ok;
    abc_ctrl_t  wv;
    logic       ev_init;
    logic       ev_cal;
    logic       ev_ready;
    logic       ev_rise;
    logic       ev_fall;
    logic       ev_sel;
    logic       thr_now;

    // ==========================================================
    // pin synchronisers for the bus reset and the settled line
    abc_pin_sync #(
        .WIDTH (2),
        .INIT  (2'h3)
    ) u_pins (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .pin_in     ({chan_settled_in, pci_rst_n_in}),
        .level_out  (pin_lvl)
    );
    assign pci_rst_n_s = pin_lvl[0];
    assign settled_s   = pin_lvl[1];

    // ==========================================================
    // bus decode: window index only, base match done by the bridge
    assign hit_ctrl = (req_in.addr[ADDR_W-1:2] == OFS_CTRL_WORD);
    assign wr_ok    = req_in.wr && hit_ctrl && (r_q.st == ST_RUN);
    assign wv       = abc_ctrl_t'(req_in.wdata[CTRL_W-1:0]);

    // interrupt event sources
    assign thr_now  = r_q.live && ana_in.buf_above_thr;
    assign ev_init  = (r_q.st == ST_INIT_RATE) && (r_q.tmr == 32'h0);
    assign ev_cal   = r_q.ctrl.cal_b && ana_in.cal_done;
    // stale synced level must not end a settle the analog has not seen
    assign ev_ready = !r_q.ctrl.ready && settled_s && !r_q.settling
                      && (r_q.st == ST_RUN);
    assign ev_rise  = thr_now && !r_q.thr_prev;
    assign ev_fall  = !thr_now && r_q.thr_prev;

    // selected event raises the request
    always_comb
    begin
        case (r_q.ctrl.irq_event_select)
            IRQ_EV_INIT:     ev_sel = ev_init;
            IRQ_EV_AUTOCAL:  ev_sel = ev_cal;
            IRQ_EV_READY:    ev_sel = ev_ready;
            IRQ_EV_THR_RISE: ev_sel = ev_rise;
            IRQ_EV_THR_FALL: ev_sel = ev_fall;
            default:         ev_sel = 1'b0;
        endcase
    end

    // ==========================================================
    // next state
    always_comb
    begin
        r_d          = r_q;
        r_d.strb     = '0;
        r_d.rvalid   = 1'b0;
        r_d.thr_prev = thr_now;
        r_d.ctrl.thr_flag = thr_now;

        // settled seen low: the analog side has taken the request
        if (!settled_s)
        begin
            r_d.settling = 1'b0;
        end

        // time since initialisation start
        if (r_q.age != 32'hFFFFFFFF)
        begin
            r_d.age = r_q.age + 32'h1;
        end
        if (r_q.age >= 32'(CYC_LIVE_P - 1))
        begin
            r_d.live = 1'b1;
        end
        if (r_q.age >= 32'(CYC_BUFSZ_P - 1))
        begin
            r_d.bufsz = 1'b1;
        end
        if (r_q.tmr != 32'h0)
        begin
            r_d.tmr = r_q.tmr - 32'h1;
        end

        // configuration and initialisation stages
        case (r_q.st)
            ST_CFG_PCI:
            begin
                if (r_q.tmr == 32'h0)
                begin
                    r_d.st  = ST_CFG_ROM;
                    r_d.tmr = 32'(CYC_ROM_CFG_P - 1);
                end
            end
            ST_CFG_ROM:
            begin
                if (r_q.tmr == 32'h0)
                begin
                    r_d.st  = ST_INIT_LOGIC;
                    r_d.tmr = 32'(CYC_LOGIC_INI_P - 1);
                end
            end
            ST_INIT_LOGIC:
            begin
                if (r_q.tmr == 32'h0)
                begin
                    r_d.st  = ST_INIT_RATE;
                    r_d.tmr = 32'(CYC_RATE_INI_P - 1);
                end
            end
            ST_INIT_RATE:
            begin
                if (r_q.tmr == 32'h0)
                begin
                    r_d.st = ST_RUN;
                    r_d.ctrl.init_b = 1'b0;
                end
            end
            default:
            begin
                r_d.st = ST_RUN;
            end
        endcase

        // ready rises first so that a new change in this cycle wins
        if (ev_ready)
        begin
            r_d.ctrl.ready = 1'b1;
        end

        // host write of the control word
        if (wr_ok)
        begin
            r_d.ctrl.input_config_select = wv.input_config_select;
            r_d.ctrl.span          = wv.span;
            r_d.ctrl.fmt_ob        = wv.fmt_ob;
            r_d.ctrl.master        = wv.master;
            r_d.ctrl.irq_event_select = wv.irq_event_select;
            r_d.ctrl.lockstep_scan = wv.lockstep_scan;
            r_d.ctrl.clr_on_sync   = wv.clr_on_sync;
            // a written zero clears the request, a one is ignored
            if (!wv.irq_flag)
            begin
                r_d.ctrl.irq_flag = 1'b0;
            end
            // mode or span change unsettles the channels
            if (wv.input_config_select != r_q.ctrl.input_config_select
                || wv.span != r_q.ctrl.span)
            begin
                r_d.ctrl.ready      = 1'b0;
                r_d.strb.settle_req = 1'b1;
            end
            if (wv.sync_b)
            begin
                if (wv.clr_on_sync)
                begin
                    r_d.strb.buf_clear = 1'b1;
                end
                else if (wv.master)
                begin
                    r_d.strb.sync_pulse = 1'b1;
                    r_d.strb.ext_sync   = 1'b1;
                    r_d.strb.settle_req = 1'b1;
                    r_d.ctrl.ready      = 1'b0;
                end
            end
            if (wv.cal_b && !r_q.ctrl.cal_b)
            begin
                r_d.ctrl.cal_b      = 1'b1;
                r_d.ctrl.cal_pass   = 1'b1;
                r_d.ctrl.ready      = 1'b0;
                r_d.strb.cal_start  = 1'b1;
                r_d.strb.settle_req = 1'b1;
            end
        end

        // autocalibration ends: bit clears, failure drops pass
        if (ev_cal)
        begin
            r_d.ctrl.cal_b = 1'b0;
            if (!ana_in.cal_ok)
            begin
                r_d.ctrl.cal_pass = 1'b0;
            end
        end
        // a request made this cycle waits for settled to drop first
        r_d.settling = r_d.settling || r_d.strb.settle_req;

        // initialise bit restores every default
        if (wr_ok && wv.init_b)
        begin
            r_d.ctrl        = abc_ctrl_t'(CTRL_RST);
            r_d.ctrl.init_b = 1'b1;
            r_d.ctrl.input_config_select = CFG_DIFF;
            r_d.st          = ST_INIT_LOGIC;
            r_d.tmr         = 32'(CYC_LOGIC_INI_P - 1);
            r_d.age         = 32'h0;
            r_d.live        = 1'b0;
            r_d.bufsz       = 1'b0;
        end

        // set wins over a clear in the same cycle
        if (ev_sel)
        begin
            r_d.ctrl.irq_flag = 1'b1;
        end

        // read data, reserved bits and locations read zero
        if (req_in.rd && (r_q.st != ST_CFG_PCI))
        begin
            r_d.rvalid = 1'b1;
            r_d.rdata  = hit_ctrl ? {14'h0, r_q.ctrl} : 32'h0;
        end

        // bus reset restarts configuration from scratch
        if (!pci_rst_n_s)
        begin
            r_d = RST_S;
        end
    end

    // state registers
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            r_q <= RST_S;
        end
        else
        begin
            r_q <= r_d;
        end
    end

    // ==========================================================
    // outputs
    assign retry_out       = (r_q.st == ST_CFG_PCI)
                             && (req_in.rd || req_in.wr);
    assign rdata_out       = r_q.rdata;
    assign rvalid_out      = r_q.rvalid;
    assign ctrl_out        = r_q.ctrl;
    assign strb_out        = r_q.strb;
    assign irq_out         = r_q.ctrl.irq_flag;
    assign cfg_busy_out    = (r_q.st != ST_RUN);
    assign rate_init_out   = (r_q.st == ST_INIT_RATE);
    assign bufsz_ready_out = r_q.bufsz;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    sequence seq_wr_sync;
        wr_ok && wv.sync_b && !wv.clr_on_sync && wv.master && !wv.init_b;
    endsequence
    sequence seq_wr_clr;
        wr_ok && wv.sync_b && wv.clr_on_sync && !wv.init_b;
    endsequence

    chk_retry_load: assert property (
        (r_q.st == ST_CFG_PCI && req_in.rd) |-> retry_out ##1 !rvalid_out)
        else $error("access during pci load not retried");
    chk_reserved_zero: assert property (
        rvalid_out |-> rdata_out[31:18] == 14'h0)
        else $error("reserved bits read nonzero");
    chk_sync_pulse: assert property (
        seq_wr_sync |=> strb_out.sync_pulse && strb_out.ext_sync
        ##1 !strb_out.sync_pulse && !ctrl_out.sync_b)
        else $error("sync pulse wrong");
    chk_sync_clear: assert property (
        seq_wr_clr |=> strb_out.buf_clear && !strb_out.sync_pulse)
        else $error("clear on sync wrong");
    chk_cal_start: assert property (
        (wr_ok && wv.cal_b && !ctrl_out.cal_b && !wv.init_b
         && pci_rst_n_s)
        |=> strb_out.cal_start && ctrl_out.cal_pass && !ctrl_out.ready)
        else $error("autocal start wrong");
    chk_irq_one_noop: assert property (
        (ctrl_out.irq_flag && !(wr_ok && !wv.irq_flag) && pci_rst_n_s)
        |=> ctrl_out.irq_flag)
        else $error("request flag lost");
    chk_irq_set_wins: assert property (
        (ev_sel && pci_rst_n_s) |=> irq_out)
        else $error("event did not raise request");
    chk_stage_order: assert property (
        (r_q.st == ST_CFG_ROM && r_q.tmr == 32'h0 && pci_rst_n_s)
        |=> r_q.st == ST_INIT_LOGIC && r_q.tmr == 32'(CYC_LOGIC_INI_P - 1))
        else $error("configuration stage order wrong");
    chk_init_done: assert property (
        (ev_init && pci_rst_n_s && !wr_ok)
        |=> !ctrl_out.init_b && !cfg_busy_out)
        else $error("initialisation end wrong");

endmodule

`default_nettype wire

// *** abc_ana_model.sv ***
// abc_ana_model: analog side model answering calibration and settling
`timescale 1ns/1ns
`default_nettype none

module abc_ana_model (
    input  wire logic              clk_sys_in,
    input  wire logic              reset_n_in,
    input  wire abc_pkg::abc_strb_t strb_in,
    input  wire logic              ok_in,
    input  wire logic              thr_in,
    output abc_pkg::abc_ana_t      ana_out,
    output logic                   settled_out
);
    import abc_pkg::*;
    logic [3:0] cal_cnt_q;
    logic [3:0] set_cnt_q;

    // calibration ends five cycles after start, settling seven after request
    always_ff @(posedge clk_sys_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cal_cnt_q <= 4'h0;
            set_cnt_q <= 4'h0;
        end
        else
        begin
            if (strb_in.cal_start)
                cal_cnt_q <= 4'h5;
            else if (cal_cnt_q != 4'h0)
                cal_cnt_q <= cal_cnt_q - 4'h1;
            if (strb_in.settle_req)
                set_cnt_q <= 4'h6;
            else if (set_cnt_q != 4'h0)
                set_cnt_q <= set_cnt_q - 4'h1;
        end
    end

    // the result line is only meaningful beside done; else it shows ok_in inverted
    assign ana_out.cal_done      = (cal_cnt_q == 4'h1);
    assign ana_out.cal_ok        = ana_out.cal_done ? ok_in : !ok_in;
    assign ana_out.buf_above_thr = thr_in;
    assign settled_out           = (set_cnt_q == 4'h0);
endmodule

`default_nettype wire

// *** abc_board_control_register_test.sv ***
// abc_board_control_register_test: self-checking bench for the control word
`timescale 1ns/1ns
`default_nettype none

module abc_board_control_register_test;
    import abc_pkg::*;
    typedef struct packed {
        logic [6:0]  a;
        logic [31:0] w;
        logic [31:0] e;
    } abc_row_t;
    logic        clk_sys_in, reset_n_in, pci_rst_n, settled, ok, thr;
    logic [31:0] rdata;
    logic        rvalid, retry, irq, busy, rate_init, bufsz_ok;
    abc_req_t    req;
    abc_ana_t    ana;
    abc_strb_t   strb;
    abc_ctrl_t   ctrl;
    int          n_fail, num_checks;
    abc_row_t    rows [5] = '{
        '{7'h00, 32'h0000_0500, 32'h0000_7500},
        '{7'h00, 32'hFFFF_0D01, 32'h0003_7501},
        '{7'h04, 32'hFFFF_FFFF, 32'h0000_0000},
        '{7'h02, 32'h0000_0516, 32'h0000_7516},
        '{7'h00, 32'h0000_0527, 32'h0000_7527}};

    // =========================================================
    // design, analog partner and clock
    abc_board_control_register #(.CYC_PCI_LOAD_P(20), .CYC_ROM_CFG_P(50),
        .CYC_LOGIC_INI_P(10), .CYC_RATE_INI_P(30), .CYC_LIVE_P(150),
        .CYC_BUFSZ_P(200)) DUT (
        .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .pci_rst_n_in(pci_rst_n), .chan_settled_in(settled),
        .req_in(req), .ana_in(ana), .rdata_out(rdata), .rvalid_out(rvalid),
        .retry_out(retry), .ctrl_out(ctrl), .strb_out(strb), .irq_out(irq),
        .cfg_busy_out(busy), .rate_init_out(rate_init),
        .bufsz_ready_out(bufsz_ok));
    abc_ana_model PART (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .strb_in(strb), .ok_in(ok), .thr_in(thr), .ana_out(ana),
        .settled_out(settled));

    initial
    begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    // =========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // full longword write, strobe taken on the middle rising edge
    task automatic wr(input logic [6:0] a, input logic [31:0] d);
        @(negedge clk_sys_in);
        req.addr = a;
        req.wdata = d;
        req.wr = 1'b1;
        @(negedge clk_sys_in);
        req.wr = 1'b0;
    endtask

    task automatic rd(input logic [6:0] a, output logic [31:0] d);
        @(negedge clk_sys_in);
        req.addr = a;
        req.rd = 1'b1;
        @(negedge clk_sys_in);
        req.rd = 1'b0;
        check({31'h0, rvalid}, 32'h1);
        d = rdata;
    endtask

    task automatic wait_ready();
        for (int i = 0; i < 100 && ctrl.ready !== 1'b1; i++)
            @(negedge clk_sys_in);
        check({31'h0, ctrl.ready}, 32'h1);
    endtask

    task automatic tally_and_finish();
        $display("TB: %0d checks, %0d errors", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // =========================================================
    // watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk_sys_in);
        n_fail++;
        tally_and_finish();
    end

    // =========================================================
    // main sequence
    initial
    begin
        logic [31:0] d;
        n_fail = 0;
        num_checks = 0;
        req = '0;
        {pci_rst_n, ok, thr, reset_n_in} = 4'b1010;
        repeat (6) @(negedge clk_sys_in);
        reset_n_in = 1'b1;
        check({14'h0, ctrl}, {14'h0, CTRL_RST});
        @(negedge clk_sys_in);
        req.rd = 1'b1;
        #1 check({31'h0, retry}, 32'h1);
        @(negedge clk_sys_in);
        req.rd = 1'b0;
        check({31'h0, rvalid}, 32'h0);
        for (int i = 0; i < 200 && rate_init !== 1'b1; i++)
            @(negedge clk_sys_in);
        check({31'h0, rate_init}, 32'h1);
        rd(7'h00, d);
        check(d, 32'h0000_383C);
        for (int i = 0; i < 400 && bufsz_ok !== 1'b1; i++)
            @(negedge clk_sys_in);
        check({30'h0, bufsz_ok, busy}, 32'h2);
        rd(7'h00, d);
        check(d, 32'h0000_783C);
        // field table: write, let channels settle, read back
        foreach (rows[k])
        begin
            wr(rows[k].a, rows[k].w);
            wait_ready();
            rd(rows[k].a, d);
            check(d, rows[k].e);
        end // rows also cover
        // software sync in master role, then buffer clear in its place
        wr(7'h00, 32'h0000_0567);
        check({30'h0, strb.sync_pulse, strb.ext_sync}, 32'h3);
        check({31'h0, ctrl.ready}, 32'h0);
        wait_ready();
        rd(7'h00, d);
        check(d, 32'h0000_7527);
        wr(7'h00, 32'h0002_0567);
        check({30'h0, strb.buf_clear, strb.sync_pulse}, 32'h2);
        // ready rise raises the request, zero clears, one does nothing
        wr(7'h00, 32'h0000_0267);
        wait_ready();
        repeat (2) @(negedge clk_sys_in);
        check({31'h0, irq}, 32'h1);
        wr(7'h00, 32'h0000_0227);
        check({31'h0, irq}, 32'h0);
        wr(7'h00, 32'h0000_0A27);
        check({31'h0, irq}, 32'h0);
        // autocalibration failing, then passing
        for (int k = 0; k < 2; k++)
        begin
            ok = k[0];
            wr(7'h00, 32'h0000_02A7);
            check({29'h0, strb.cal_start, ctrl.cal_b, ctrl.cal_pass}, 32'h7);
            for (int i = 0; i < 20 && ctrl.cal_b !== 1'b0; i++)
                @(negedge clk_sys_in);
            check({30'h0, ctrl.cal_b, ctrl.cal_pass}, k);
        end
        // threshold flag follows the buffer level, edges raise the request
        wait_ready();
        wr(7'h00, 32'h0000_0427);
        check({31'h0, irq}, 32'h0);
        thr = 1'b0;
        @(negedge clk_sys_in);
        check({30'h0, ctrl.thr_flag, irq}, 32'h1);
        wr(7'h00, 32'h0000_0327);
        thr = 1'b1;
        @(negedge clk_sys_in);
        check({30'h0, ctrl.thr_flag, irq}, 32'h3);
        // reinitialise: defaults back, init event at the end
        wr(7'h00, 32'h0000_8000);
        check({30'h0, ctrl.init_b, busy}, 32'h3);
        for (int i = 0; i < 200 && busy !== 1'b0; i++)
            @(negedge clk_sys_in);
        check({20'h0, ctrl.init_b, ctrl[10:0]}, 32'h3C);
        check({31'h0, irq}, 32'h1);
        // bus reset in mid-run restarts configuration
        pci_rst_n = 1'b0;
        repeat (8) @(negedge clk_sys_in);
        check({14'h0, ctrl}, {14'h0, CTRL_RST});
        pci_rst_n = 1'b1;
        @(negedge clk_sys_in);
        req.rd = 1'b1;
        #1 check({31'h0, retry}, 32'h1);
        @(negedge clk_sys_in);
        req.rd = 1'b0;
        tally_and_finish();
    end
endmodule

`default_nettype wire
